// ==== pkg/rtc_irq_defs.svh ====
// constants for the periodic interrupt and oscillator halt block
`ifndef RTC_IRQ_DEFS_SVH
`define RTC_IRQ_DEFS_SVH

// ----------------------------------------
// register port
// ----------------------------------------
`define ADDR_W              4
`define DATA_W              4
`define REG_SEL_OFS         4'h0
`define REG_CTRL_OFS        4'h1
`define SEL_RESET           4'h0
`define SEL_MODE_BIT        3
`define CTRL_PEND_BIT       0
`define CTRL_HALT_BIT       3

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_HZ              50000000
`define CLK_PERIOD_NS       20
`define TEST_DELAY_MS       2500
`define TEST_DELAY_CYCLES   (`TEST_DELAY_MS * (`CLK_HZ / 1000))
`define OSC_PERIOD_NS       30518
`define HALT_WINDOW_PERIODS 4
`define HALT_WINDOW_CYCLES  ((`HALT_WINDOW_PERIODS * `OSC_PERIOD_NS) / `CLK_PERIOD_NS)
`define TEST_CNT_W          27
`define HALT_CNT_W          16

// ----------------------------------------
// oscillator divider taps, counted in oscillator edges
// ----------------------------------------
`define DIV_W               15
`define TAP_1024HZ          4
`define TAP_2HZ             13
`define TAP_1HZ             14

`endif

// ==== pkg/rtc_irq_pkg.sv ====
// types for the periodic interrupt and oscillator halt block
package rtc_irq_pkg;

  typedef enum logic [1:0] {
    PS_OFF  = 2'b00,
    PS_ON   = 2'b01,
    PS_1024 = 2'b10,
    PS_2HZ  = 2'b11
  } pulse_sel_type;

  typedef enum logic [2:0] {
    LV_SEC    = 3'b000,
    LV_10SEC  = 3'b001,
    LV_MIN    = 3'b010,
    LV_10MIN  = 3'b011,
    LV_HOUR   = 3'b100,
    LV_DAY    = 3'b101,
    LV_WEEK   = 3'b110,
    LV_MONTH  = 3'b111
  } level_sel_type;

  typedef enum logic [1:0] {
    T_IDLE  = 2'b00,
    T_COUNT = 2'b01,
    T_PULSE = 2'b11
  } test_state_type;

endpackage

// ==== pkg/osc_if.sv ====
// oscillator edge, divided square waves and halt indication between modules
`timescale 1ns/1ps
`default_nettype none

interface osc_if;
  logic       osc_edge;
  logic       sense_en;
  logic [2:0] sq;
  logic       halted;

  modport core (output osc_edge, output sense_en, input sq, input halted);
  modport div  (input osc_edge, output sq);
  modport det  (input osc_edge, input sense_en, output halted);
endinterface

`default_nettype wire

// ==== src/osc_divider.sv ====
// divider of oscillator edges into 1024 hz, 2 hz and 1 hz square waves
`timescale 1ns/1ps
`default_nettype none
`include "rtc_irq_defs.svh"

module osc_divider
  import rtc_irq_pkg::*;
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // oscillator side
  osc_if.div        osc
);

  logic [`DIV_W-1:0] div_q;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      div_q <= '0;
    else if (osc.osc_edge)
      div_q <= div_q + 1'b1;
  end

  // sq[0] 1024 hz, sq[1] 2 hz, sq[2] 1 hz; high half of each period
  localparam int TAPS [3] = '{`TAP_1024HZ, `TAP_2HZ, `TAP_1HZ};

  for (genvar i = 0; i < 3; i++)
  begin : g_tap
    assign osc.sq[i] = div_q[TAPS[i]];
  end

endmodule

`default_nettype wire

// ==== src/halt_detect.sv ====
// oscillator halt detector timed from the system clock
`timescale 1ns/1ps
`default_nettype none
`include "rtc_irq_defs.svh"

module halt_detect
  import rtc_irq_pkg::*;
#(
  parameter logic [`HALT_CNT_W-1:0] WINDOW_CYCLES = `HALT_CNT_W'(`HALT_WINDOW_CYCLES)
)
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // oscillator side
  osc_if.det        osc
);

  logic [`HALT_CNT_W-1:0] gap_q;
  logic                   halted_q;

  // gap since the last oscillator edge; sensing off restarts the window
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      gap_q <= '0;
    else if (!osc.sense_en || osc.osc_edge)
      gap_q <= '0;
    else if (gap_q != WINDOW_CYCLES)
      gap_q <= gap_q + 1'b1;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      halted_q <= 1'b0;
    else
      halted_q <= osc.sense_en && (gap_q == WINDOW_CYCLES);
  end

  assign osc.halted = halted_q;

endmodule

`default_nettype wire

// ==== src/rtc_irq_top.sv ====
// periodic interrupt generator and oscillator halt flag of a real-time clock
//
// Operation
// - a detected oscillator stop sets the halt flag from 0 to 1
// - host arms detection by writing control with halt flag 0, then polls
// - power-up reset with access-enable low leaves the halt flag at 1
// - access-enable high suspends halt detection; flag keeps its value
// - halt flag stays 1 after oscillator restarts, until host clears it
// - access-enable held high gives a 1 hz test pulse about 2.5 s later
// - interrupt pin is open drain: pulls low when asserted, else released
// - top select bit: 0 pulse mode, 1 level mode
// - pulse mode ignores second select bit; low bits 00 release output
// - pulse mode low bits 01 hold the output low
// - low bits 10 give 1024 hz at 50 percent, 11 give 2 hz
// - level codes 000 every second, 001 every ten seconds
// - level codes 010 every minute, 011 every ten minutes
// - level codes 100 every hour, 101 every day at midnight
// - level codes 110 weekly at weekday 0, 111 monthly on day 1
// - level mode: host writes pending flag; 1 asserts, 0 releases
// - pulse mode: pending flag not writable, it mirrors the output
// - access-enable high under 1.5 s produces no test pulse
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_irq_defs.svh"

module rtc_irq_top
  import rtc_irq_pkg::*;
#(
  parameter logic [`TEST_CNT_W-1:0] TEST_DELAY_CYCLES  = `TEST_CNT_W'(`TEST_DELAY_CYCLES),
  parameter logic [`HALT_CNT_W-1:0] HALT_WINDOW_CYCLES = `HALT_CNT_W'(`HALT_WINDOW_CYCLES)
)
(
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              reset_n,
  // register port
  input  wire logic [`ADDR_W-1:0] reg_addr,
  input  wire logic [`DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [`DATA_W-1:0]     reg_rdata,
  // pins
  input  wire logic              osc_in,
  input  wire logic              access_en,
  input  wire logic              irq_out_n_i,
  output logic                   irq_out_n_o,
  output logic                   irq_out_n_oe_n,
  // calendar counters, same clock
  input  wire logic              sec_tick,
  input  wire logic [7:0]        sec_bcd,
  input  wire logic [7:0]        min_bcd,
  input  wire logic [7:0]        hour_bcd,
  input  wire logic [2:0]        weekday,
  input  wire logic [7:0]        day_bcd
);

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] osc_sync_q;
  logic [1:0] ae_sync_q;
  logic [1:0] pin_sync_q;

  // osc_sync_q[0] feeds only osc_sync_q[1]; the edge looks at [1] and [2]
  always_ff @(posedge mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      osc_sync_q <= '0;
      ae_sync_q  <= '0;
      pin_sync_q <= 2'b11;
    end
    else
    begin
      osc_sync_q <= {osc_sync_q[1:0], osc_in};
      ae_sync_q  <= {ae_sync_q[0], access_en};
      pin_sync_q <= {pin_sync_q[0], irq_out_n_i};
    end
  end

  logic access_en_s;
  logic pin_low_s;

  assign access_en_s = ae_sync_q[1];
  assign pin_low_s   = !pin_sync_q[1];

  // ----------------------------------------
  // oscillator divider and halt detector
  // ----------------------------------------
  osc_if osc ();

  assign osc.osc_edge = osc_sync_q[1] && !osc_sync_q[2];
  assign osc.sense_en = !access_en_s;

  osc_divider u_div
  (
    .mclk  (mclk),
    .rst_n (rst_n_q),
    .osc   (osc)
  );

  halt_detect #(
    .WINDOW_CYCLES (HALT_WINDOW_CYCLES)
  ) u_det
  (
    .mclk  (mclk),
    .rst_n (rst_n_q),
    .osc   (osc)
  );

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  logic [`DATA_W-1:0] sel_q;
  logic               wr_sel;
  logic               wr_ctrl;
  logic               level_mode;

  assign wr_sel     = reg_wr && (reg_addr == `REG_SEL_OFS);
  assign wr_ctrl    = reg_wr && (reg_addr == `REG_CTRL_OFS);
  assign level_mode = sel_q[`SEL_MODE_BIT];

  always_ff @(posedge mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      sel_q <= `SEL_RESET;
    else if (wr_sel)
      sel_q <= reg_wdata;
  end

  // ----------------------------------------
  // oscillator halt flag
  // ----------------------------------------
  logic osc_halt_flag_q;

  // reset stands for power-up; detection set wins over a host clear
  always_ff @(posedge mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      osc_halt_flag_q <= 1'b1;
    else if (osc.halted)
      osc_halt_flag_q <= 1'b1;
    else if (wr_ctrl && !reg_wdata[`CTRL_HALT_BIT])
      osc_halt_flag_q <= 1'b0;
  end

  // ----------------------------------------
  // level mode boundaries
  // ----------------------------------------
  logic sec_zero;
  logic min_zero;
  logic hour_zero;
  logic boundary;

  assign sec_zero  = (sec_bcd == 8'h00);
  assign min_zero  = (min_bcd == 8'h00);
  assign hour_zero = (hour_bcd == 8'h00);

  always_comb
  begin
    unique case (level_sel_type'(sel_q[2:0]))
      LV_SEC:   boundary = 1'b1;
      LV_10SEC: boundary = (sec_bcd[3:0] == 4'h0);
      LV_MIN:   boundary = sec_zero;
      LV_10MIN: boundary = sec_zero && (min_bcd[3:0] == 4'h0);
      LV_HOUR:  boundary = sec_zero && min_zero;
      LV_DAY:   boundary = sec_zero && min_zero && hour_zero;
      LV_WEEK:  boundary = sec_zero && min_zero && hour_zero && (weekday == 3'h0);
      LV_MONTH: boundary = sec_zero && min_zero && hour_zero && (day_bcd == 8'h01);
    endcase
  end

  // ----------------------------------------
  // pending flag
  // ----------------------------------------
  logic irq_pending_flag_q;

  // boundary set wins over a host write of 0 in the same cycle
  always_ff @(posedge mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      irq_pending_flag_q <= 1'b0;
    else if (!level_mode)
      irq_pending_flag_q <= 1'b0;
    else if (sec_tick && boundary)
      irq_pending_flag_q <= 1'b1;
    else if (wr_ctrl)
      irq_pending_flag_q <= reg_wdata[`CTRL_PEND_BIT];
  end

  // ----------------------------------------
  // frequency test sequencer
  // ----------------------------------------
  test_state_type          test_q;
  logic [`TEST_CNT_W-1:0]  test_cnt_q;

  always_ff @(posedge mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      test_q <= T_IDLE;
    else if (!access_en_s)
      test_q <= T_IDLE;
    else
    begin
      unique case (test_q)
        T_IDLE:  test_q <= T_COUNT;
        T_COUNT: if (test_cnt_q == TEST_DELAY_CYCLES)
                   test_q <= T_PULSE;
        T_PULSE: test_q <= T_PULSE;
        default: test_q <= T_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      test_cnt_q <= '0;
    else if (test_q != T_COUNT)
      test_cnt_q <= '0;
    else
      test_cnt_q <= test_cnt_q + 1'b1;
  end

  // ----------------------------------------
  // interrupt output
  // ----------------------------------------
  logic assert_d;

  always_comb
  begin
    if (test_q == T_PULSE)
      assert_d = osc.sq[2];
    else if (level_mode)
      assert_d = irq_pending_flag_q;
    else
    begin
      unique case (pulse_sel_type'(sel_q[1:0]))
        PS_OFF:  assert_d = 1'b0;
        PS_ON:   assert_d = 1'b1;
        PS_1024: assert_d = osc.sq[0];
        PS_2HZ:  assert_d = osc.sq[1];
      endcase
    end
  end

  logic irq_oe_n_q;
  logic irq_o_q;

  // pin is only ever pulled low; the pull-up makes the high level
  always_ff @(posedge mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      irq_oe_n_q <= 1'b1;
      irq_o_q    <= 1'b0;
    end
    else
    begin
      irq_oe_n_q <= !assert_d;
      irq_o_q    <= 1'b0;
    end
  end

  assign irq_out_n_o    = irq_o_q;
  assign irq_out_n_oe_n = irq_oe_n_q;

  // ----------------------------------------
  // register read
  // ----------------------------------------
  logic [`DATA_W-1:0] rdata_q;
  logic               pend_view;

  // in pulse mode the flag shows the pin level as seen back from outside
  assign pend_view = level_mode ? irq_pending_flag_q : pin_low_s;

  always_ff @(posedge mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      rdata_q <= '0;
    else if (reg_rd && (reg_addr == `REG_SEL_OFS))
      rdata_q <= sel_q;
    else if (reg_rd && (reg_addr == `REG_CTRL_OFS))
      rdata_q <= {osc_halt_flag_q, 2'b00, pend_view};
    else
      rdata_q <= '0;
  end

  assign reg_rdata = rdata_q;

endmodule

`default_nettype wire

// ==== dv/rtc_irq_props.sv ====
// port assertions for the periodic interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "rtc_irq_defs.svh"

module rtc_irq_props
  import rtc_irq_pkg::*;
(
  // clock and reset
  input wire logic       mclk,
  input wire logic       reset_n,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [3:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [3:0] reg_rdata,
  // pins
  input wire logic       access_en,
  input wire logic       irq_out_n_o,
  input wire logic       irq_out_n_oe_n,
  input wire logic       sec_tick
);
  // ------
  // select shadow
  // ------
  logic [3:0] sel_q;
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
      sel_q <= `SEL_RESET;
    else if (reg_wr && reg_addr == `REG_SEL_OFS)
      sel_q <= reg_wdata;

  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // ------
  // properties
  // ------
  // test pulse overrides the select, so the pulse-mode and level-hold pin checks wait for a quiet enable
  sequence s_quiet;
    !access_en [*6];
  endsequence
  sequence s_sel_wr_rd;
    reg_wr && reg_addr == `REG_SEL_OFS ##2 reg_rd && reg_addr == `REG_SEL_OFS;
  endsequence
  sequence s_ctrl_wr(logic b);
    reg_wr && reg_addr == `REG_CTRL_OFS && reg_wdata[`CTRL_PEND_BIT] == b;
  endsequence
  property p_rdata_idle;
    !reg_rd |=> reg_rdata == 4'h0;
  endproperty
  property p_drive_zero;
    irq_out_n_o == 1'b0;
  endproperty
  property p_sel_back;
    s_sel_wr_rd |=> reg_rdata == $past(reg_wdata, 3);
  endproperty
  property p_pulse_off;
    s_quiet ##0 (!sel_q[3] && sel_q[1:0] == 2'b00 && sel_q == $past(sel_q) && sel_q == $past(sel_q, 2))
      |-> irq_out_n_oe_n;
  endproperty
  property p_pulse_on;
    s_quiet ##0 (!sel_q[3] && sel_q[1:0] == 2'b01 && sel_q == $past(sel_q) && sel_q == $past(sel_q, 2))
      |-> !irq_out_n_oe_n;
  endproperty
  property p_level_sec;
    sel_q == 4'h8 && sec_tick |-> ##2 !irq_out_n_oe_n;
  endproperty
  property p_level_set;
    sel_q[3] ##0 s_ctrl_wr(1'b1) |-> ##2 !irq_out_n_oe_n;
  endproperty
  property p_level_clr;
    (sel_q[3] && !sec_tick) ##0 s_ctrl_wr(1'b0) ##1 (!sec_tick && !reg_wr) |=> irq_out_n_oe_n;
  endproperty
  property p_level_hold;
    s_quiet ##0 (sel_q[3] && !irq_out_n_oe_n && !reg_wr && !$past(reg_wr)) ##1 !reg_wr |=> !irq_out_n_oe_n;
  endproperty

  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside a read");
  a_drive_zero: assert property (p_drive_zero) else $error("pin drive value not low");
  a_sel_back: assert property (p_sel_back) else $error("select readback differs");
  a_pulse_off: assert property (p_pulse_off) else $error("pin not released when off");
  a_pulse_on: assert property (p_pulse_on) else $error("pin not held low");
  a_level_sec: assert property (p_level_sec) else $error("no assert on second tick");
  a_level_set: assert property (p_level_set) else $error("flag write did not assert pin");
  a_level_clr: assert property (p_level_clr) else $error("flag clear did not release pin");
  a_level_hold: assert property (p_level_hold) else $error("pin released without clear");
endmodule

`default_nettype wire

// ==== dv/rtc_far_side.sv ====
// far side model: crystal oscillator and pulled-up interrupt line
`timescale 1ns/1ps
`default_nettype none

module rtc_far_side
(
  // clock and control
  input  wire logic mclk,
  input  wire logic osc_run,
  // pins
  input  wire logic irq_out_n_o,
  input  wire logic irq_out_n_oe_n,
  output logic      osc_in,
  output logic      irq_pin
);
  // oscillator scaled to two clock cycles so divided rates fit a short run
  initial osc_in = 1'b0;
  always @(posedge mclk)
    if (osc_run)
      osc_in <= ~osc_in;
  // released line goes high through the pull-up
  assign irq_pin = irq_out_n_oe_n ? 1'b1 : irq_out_n_o;
endmodule

`default_nettype wire

// ==== dv/rtc_irq_top_bench.sv ====
// self-checking bench for the periodic interrupt and halt flag block
`timescale 1ns/1ps
`default_nettype none
`include "rtc_irq_defs.svh"

module rtc_irq_top_bench
  import rtc_irq_pkg::*;
;
  // ------
  // set-up
  // ------
  localparam int TDLY = 200;
  localparam int HWIN = 50;
  // {sec, min, hour, weekday, day}: hits on a boundary, misses just off it
  localparam logic [39:0] HIT [8] = '{40'h1723050215, 40'h2023050215, 40'h0023050215,
    40'h0040050215, 40'h0000050215, 40'h0000000215, 40'h0000000015, 40'h0000000201};
  localparam logic [39:0] MISS [8] = '{40'h1723050215, 40'h2123050215, 40'h3023050215,
    40'h0041050215, 40'h0010050215, 40'h0000010215, 40'h0000000315, 40'h0000000202};
  logic       mclk, reset_n, reg_wr, reg_rd, access_en, sec_tick;
  logic       osc_run, osc_in, irq_pin, irq_o, irq_oe_n;
  logic [3:0] reg_addr, reg_wdata, reg_rdata;
  logic [7:0] sec_bcd, min_bcd, hour_bcd, day_bcd;
  logic [2:0] weekday;
  int         fails, cmp_count;

  initial mclk = 1'b0;
  always #(`CLK_PERIOD_NS / 2) mclk = ~mclk;

  rtc_irq_top #(
    .TEST_DELAY_CYCLES (`TEST_CNT_W'(TDLY)),
    .HALT_WINDOW_CYCLES(`HALT_CNT_W'(HWIN))
  ) uut (
    .mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .osc_in(osc_in), .access_en(access_en), .irq_out_n_i(irq_pin),
    .irq_out_n_o(irq_o), .irq_out_n_oe_n(irq_oe_n), .sec_tick(sec_tick), .sec_bcd(sec_bcd),
    .min_bcd(min_bcd), .hour_bcd(hour_bcd), .weekday(weekday), .day_bcd(day_bcd)
  );
  rtc_far_side far (.mclk(mclk), .osc_run(osc_run), .irq_out_n_o(irq_o), .irq_out_n_oe_n(irq_oe_n),
    .osc_in(osc_in), .irq_pin(irq_pin));

  // ------
  // helpers
  // ------
  task automatic cmp(input string what, input logic [3:0] e, input logic [3:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic cmp_n(input string what, input int e, input int g);
    cmp_count++;
    if (g != e)
    begin
      fails++;
      $display("Error %s expected %0d seen %0d", what, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [3:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic chk_rd(input string what, input logic [3:0] a, input logic [3:0] e);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    cmp(what, e, reg_rdata);
  endtask
  task automatic chk_pin(input logic e, input int n);
    cyc(n);
    @(negedge mclk);
    cmp("pin", {3'b000, e}, {3'b000, irq_pin});
  endtask
  task automatic tick(input logic [39:0] t);
    @(posedge mclk);
    {sec_bcd, min_bcd, hour_bcd} <= t[39:16];
    weekday  <= t[10:8];
    day_bcd  <= t[7:0];
    sec_tick <= 1'b1;
    @(posedge mclk);
    sec_tick <= 1'b0;
  endtask
  // waits for a full low phase; a zero high limit skips the high phase
  task automatic measure(input int lim, input int hlim, output int lo, output int hi);
    int n;
    for (n = 0; irq_pin !== 1'b1 && n < lim; n++) @(negedge mclk);
    for (n = 0; irq_pin !== 1'b0 && n < lim; n++) @(negedge mclk);
    for (lo = 0; irq_pin === 1'b0 && lo < lim; lo++) @(negedge mclk);
    for (hi = 0; irq_pin === 1'b1 && hi < hlim; hi++) @(negedge mclk);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ------
  // scenarios
  // ------
  task automatic t_reset;
    chk_rd("ctrl", `REG_CTRL_OFS, 4'h8);
    chk_rd("sel", `REG_SEL_OFS, `SEL_RESET);
    chk_rd("unmapped", 4'h5, 4'h0);
    wr(4'h7, 4'hf);
    chk_rd("sel", `REG_SEL_OFS, `SEL_RESET);
    wr(`REG_SEL_OFS, 4'h4);
    chk_rd("sel", `REG_SEL_OFS, 4'h4);
  endtask
  task automatic t_halt;
    wr(`REG_CTRL_OFS, 4'h0);
    cyc(3 * HWIN);
    chk_rd("halt", `REG_CTRL_OFS, 4'h0);
    cyc(1);
    osc_run <= 1'b0;
    cyc(2 * HWIN);
    chk_rd("halt", `REG_CTRL_OFS, 4'h8);
    cyc(1);
    osc_run <= 1'b1;
    cyc(3 * HWIN);
    chk_rd("halt", `REG_CTRL_OFS, 4'h8);
    wr(`REG_CTRL_OFS, 4'h0);
    chk_rd("halt", `REG_CTRL_OFS, 4'h0);
    cyc(1);
    access_en <= 1'b1;
    osc_run   <= 1'b0;
    chk_pin(1'b1, 2 * HWIN);
    chk_rd("halt", `REG_CTRL_OFS, 4'h0);
    cyc(1);
    osc_run <= 1'b1;
    cyc(8);
    access_en <= 1'b0;
    cyc(3 * HWIN);
    chk_rd("halt", `REG_CTRL_OFS, 4'h0);
  endtask
  task automatic t_pulse;
    int lo;
    int hi;
    for (int k = 0; k < 4; k++)
    begin
      wr(`REG_SEL_OFS, {1'b0, k[1], 1'b0, k[0]});
      wr(`REG_CTRL_OFS, 4'h1);
      chk_pin(!k[0], 4);
      chk_rd("pend", `REG_CTRL_OFS, {3'b000, k[0]});
    end
    wr(`REG_SEL_OFS, 4'h6);
    measure(200, 200, lo, hi);
    cmp_n("1024 low", 32, lo);
    cmp_n("1024 high", 32, hi);
    wr(`REG_SEL_OFS, 4'h3);
    measure(17000, 0, lo, hi);
    cmp_n("2hz low", 16384, lo);
  endtask
  task automatic t_level;
    // a flag write refused in pulse mode must not show up once level mode is on
    wr(`REG_CTRL_OFS, 4'h1);
    wr(`REG_SEL_OFS, 4'h8);
    chk_pin(1'b1, 3);
    for (int c = 0; c < 8; c++)
    begin
      wr(`REG_SEL_OFS, 4'(8 + c));
      wr(`REG_CTRL_OFS, 4'h0);
      if (c != 0)
        tick(MISS[c]);
      chk_pin(1'b1, 3);
      tick(HIT[c]);
      chk_pin(1'b0, 3);
      chk_pin(1'b0, 20);
      chk_rd("pend", `REG_CTRL_OFS, 4'h1);
      wr(`REG_CTRL_OFS, 4'h0);
      chk_pin(1'b1, 3);
    end
    wr(`REG_CTRL_OFS, 4'h1);
    chk_pin(1'b0, 3);
  endtask
  task automatic t_test;
    int n;
    wr(`REG_SEL_OFS, 4'he);
    wr(`REG_CTRL_OFS, 4'h0);
    access_en <= 1'b1;
    chk_pin(1'b1, 150);
    for (n = 0; irq_pin !== 1'b0 && n < 34000; n++) @(negedge mclk);
    cmp_n("test pulse", 1, int'(n > 45 && n < 34000));
    cyc(1);
    access_en <= 1'b0;
    cyc(8);
  endtask

  initial
  begin
    {reset_n, reg_wr, reg_rd, access_en, sec_tick} = '0;
    {reg_addr, reg_wdata, weekday} = '0;
    {sec_bcd, min_bcd, hour_bcd, day_bcd} = '0;
    osc_run   = 1'b1;
    fails     = 0;
    cmp_count = 0;
    cyc(16);
    reset_n <= 1'b1;
    cyc(3);
    t_reset();
    t_halt();
    t_pulse();
    t_level();
    t_test();
    test_done();
  end

  initial
  begin
    cyc(96000);
    fails++;
    test_done();
  end
endmodule

bind rtc_irq_top rtc_irq_props chk (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .access_en(access_en), .irq_out_n_o(irq_out_n_o),
  .irq_out_n_oe_n(irq_out_n_oe_n), .sec_tick(sec_tick));

`default_nettype wire
